/* hw/impf_pkg.sv */
// Purpose: shared constants and types of the multicast proxy forwarder
// Assumes: 100 MHz clk, group and source timers counted in whole seconds
// Notes: rule summary of the block follows
// Operation
// RQ1: act as igmpv3 router on customer interfaces
// RQ2: keep separate reception state per customer interface
// RQ3: always querier downstream, ignore querier election
// RQ4: upstream acts only as group member
// RQ5: report database changes, answer upstream queries
// RQ6: never run router role upstream
// RQ7: record: group, timer, mode, timed sources
// RQ8: merged record: group, mode, sources, untimed
// RQ9: convert v1/v2 records, strip timers
// RQ10: drop timed sources from exclude records
// RQ11: merge records with igmpv3 single interface rules
// RQ12: replicate downstream only where someone joined
// RQ13: never forward back to ingress interface
// RQ14: terminate igmp, never relay it
// RQ15: flood local scope to other customer interfaces
// RQ16: forward customer multicast upstream, except igmp/admin
// RQ17: v2 report puts only that group in v2
// RQ18: igmp version independent per interface
// RQ19: downstream forwarding honours filter mode, sources
// RQ20: recompute merged record on any change
package impf_pkg;
  localparam int          CLK_PERIOD_NS   = 10; // system clock period
  localparam int          TICK_PERIOD_NS  = 1_000_000_000; // one second aging tick
  localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS; // cycles per tick
  localparam int          TW              = 9; // timer width in bits, timers count seconds
  localparam logic [8:0]  GMI_SECS        = 9'h104; // group membership interval, 260 s
  localparam logic [8:0]  LMQT_SECS       = 9'h002; // last member query time, 2 s
  localparam logic [7:0]  QINT_RST        = 8'h7D; // query interval, 125 s
  localparam logic [15:0] LOCAL_SCOPE_PFX = 16'hEFFF; // 239.255.0.0/16
  localparam logic [7:0]  ADMIN_SCOPE_PFX = 8'hEF; // 239.0.0.0/8
  localparam logic [1:0]  REG_CTRL        = 2'h0; // control register index
  localparam logic [1:0]  REG_QINT        = 2'h1; // query interval register index
  localparam logic [1:0]  REG_STATUS      = 2'h2; // status register index
  localparam logic        CTRL_EN_RST     = 1'b1; // enabled after reset
  localparam int          CTRL_EN_BIT     = 0; // enable bit position
  localparam int          STAT_UPV2_BIT   = 0; // upstream v2 compat bit
  localparam int          STAT_DROP_LSB   = 8; // drop counter field
  localparam int          STAT_NGRP_LSB   = 16; // active group count field

  // igmp message kinds as seen by the parser in front of this block
  typedef enum logic [2:0] {
    IMPF_MSG_QUERY_V3 = 3'h0,
    IMPF_MSG_QUERY_V2 = 3'h1,
    IMPF_MSG_REPORT12 = 3'h2,
    IMPF_MSG_LEAVE_V2 = 3'h3,
    IMPF_MSG_ALLOW    = 3'h4,
    IMPF_MSG_EXCLUDE  = 3'h5,
    IMPF_MSG_BLOCK    = 3'h6
  } impf_msg_type;
endpackage

/* hw/impf_proxy_forwarder.sv */
// Purpose: igmp proxy tables, merged membership database and per-packet replication decision
// Assumes: messages and packet headers come parsed, one per cycle, from logic on clk
// Notes: interface index N_CFI is the operator-facing side; 0..N_CFI-1 are customer-facing
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module impf_proxy_forwarder
  import impf_pkg::*;
#(
  parameter int N_CFI       = 2,           // customer-facing interfaces
  parameter int N_GRP       = 4,           // group slots
  parameter int N_SRC       = 2,           // source slots per group
  parameter int TICK_CYC    = TICK_CYCLES, // cycles per one-second tick
  localparam int IFW        = $clog2(N_CFI + 1),
  localparam int GW         = (N_GRP > 1) ? $clog2(N_GRP) : 1
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [1:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   igmp_valid,
  input  wire logic [IFW-1:0]         igmp_if,
  input  wire impf_msg_type           igmp_kind,
  input  wire logic [31:0]            igmp_group,
  input  wire logic [31:0]            igmp_src,
  input  wire logic                   igmp_has_src,
  input  wire logic                   pkt_valid,
  input  wire logic [IFW-1:0]         pkt_if,
  input  wire logic [31:0]            pkt_group,
  input  wire logic [31:0]            pkt_src,
  input  wire logic                   pkt_is_igmp,
  output logic                        fwd_valid,
  output logic      [N_CFI:0]         fwd_mask,
  output logic      [N_CFI-1:0]       query_mask,
  output logic                        up_rpt_valid,
  output logic      [31:0]            up_rpt_group,
  output logic                        up_rpt_excl,
  output logic                        up_rpt_v2,
  output logic      [N_SRC-1:0]       up_rpt_src_mask,
  output logic      [N_SRC*32-1:0]    up_rpt_src_addr
);
  localparam int TCW = $clog2(TICK_CYC);

  // per customer interface, per group slot state, then shared addresses and drop count
  logic             act [N_CFI][N_GRP], next_act [N_CFI][N_GRP]; // record present
  logic             excl [N_CFI][N_GRP], next_excl [N_CFI][N_GRP]; // filter mode exclude
  logic             v2 [N_CFI][N_GRP], next_v2 [N_CFI][N_GRP]; // v2 compatibility of this group only
  logic [TW-1:0]    gtmr [N_CFI][N_GRP], next_gtmr [N_CFI][N_GRP]; // group timer
  logic [TW-1:0]    v2tmr [N_CFI][N_GRP], next_v2tmr [N_CFI][N_GRP]; // older host present timer
  logic [N_SRC-1:0] lst [N_CFI][N_GRP], next_lst [N_CFI][N_GRP]; // source listed
  logic [TW-1:0]    stmr [N_CFI][N_GRP][N_SRC], next_stmr [N_CFI][N_GRP][N_SRC]; // source timers
  logic [31:0]      grp_addr [N_GRP], next_grp_addr [N_GRP]; // group address, shared by interfaces
  logic [31:0]      src_addr [N_GRP][N_SRC], next_src_addr [N_GRP][N_SRC]; // source addresses, shared
  logic [7:0]       drops, next_drops; // joins refused for lack of slots

  // merged database, timers stripped
  logic [N_GRP-1:0]    mrg_act, mrg_ex, grp_busy, grp_used;
  logic [N_SRC-1:0]    mrg_src [N_GRP], db_src [N_GRP];
  logic [N_GRP-1:0]    db_act, db_ex, next_db_act, next_db_ex;
  logic [N_GRP-1:0]    pend, next_pend; // upstream report owed

  // misc control state
  logic [TCW-1:0]      tcnt, next_tcnt; // one-second divider
  logic                tick;
  logic [7:0]          qcnt, next_qcnt; // seconds to next general query
  logic [7:0]          qint, next_qint;
  logic                en, next_en;
  logic [TW-1:0]       up_v2tmr, next_up_v2tmr; // upstream v2 querier present

  // next values of output registers
  logic [31:0]         next_reg_rdata;
  logic                next_fwd_valid;
  logic [N_CFI:0]      next_fwd_mask;
  logic [N_CFI-1:0]    next_query_mask;
  logic                next_up_rpt_valid, next_up_rpt_excl, next_up_rpt_v2;
  logic [31:0]         next_up_rpt_group;
  logic [N_SRC-1:0]    next_up_rpt_src_mask;
  logic [N_SRC*32-1:0] next_up_rpt_src_addr;

  // slot lookup, used for reports and for packets
  function automatic logic [GW:0] find_grp(input logic [31:0] a);
    logic [GW:0] r;
    r = '0;
    for (int g = N_GRP - 1; g >= 0; g--) begin
      if (grp_used[g] && grp_addr[g] == a) r = {1'b1, GW'(g)};
    end
    return r;
  endfunction

  // which source slots of a group carry address a
  function automatic logic [N_SRC-1:0] src_hits(input logic [GW-1:0] g, input logic [31:0] a);
    logic [N_SRC-1:0] m;
    m = '0;
    for (int s = 0; s < N_SRC; s++) m[s] = (src_addr[g][s] == a);
    return m;
  endfunction

  // sources whose timer is still running
  function automatic logic [N_SRC-1:0] running(input logic [GW-1:0] g, input int i);
    logic [N_SRC-1:0] m;
    m = '0;
    for (int s = 0; s < N_SRC; s++) m[s] = (stmr[i][g][s] != '0);
    return m;
  endfunction

  assign tick = (tcnt == TCW'(TICK_CYC - 1));

  // merge: strip timers, drop running exclude sources, combine
  always_comb begin
    logic [N_SRC-1:0] inc_or, ex_and;
    inc_or = '0;
    ex_and = '1;
    for (int g = 0; g < N_GRP; g++) begin
      inc_or = '0;
      ex_and = '1;
      mrg_act[g] = 1'b0;
      mrg_ex[g]  = 1'b0;
      grp_busy[g] = 1'b0;
      for (int i = 0; i < N_CFI; i++) begin
        if (act[i][g]) begin
          mrg_act[g]  = 1'b1;
          grp_busy[g] = 1'b1;
          if (excl[i][g]) begin
            mrg_ex[g] = 1'b1;
            ex_and    = ex_and & lst[i][g] & ~running(GW'(g), i); // RQ10 RQ9
          end else begin
            inc_or = inc_or | (lst[i][g] & running(GW'(g), i));
          end
        end
      end
      mrg_src[g] = mrg_ex[g] ? (ex_and & ~inc_or) : inc_or; // RQ11 RQ8
    end
    grp_used = grp_busy | pend | db_act;
  end

  // database image and pending upstream reports
  always_comb begin
    logic [GW:0] pick;
    pick                 = '0;
    next_db_act          = mrg_act;
    next_db_ex           = mrg_ex;
    next_pend            = pend;
    next_up_rpt_valid    = 1'b0;
    next_up_rpt_group    = up_rpt_group;
    next_up_rpt_excl     = up_rpt_excl;
    next_up_rpt_src_mask = up_rpt_src_mask;
    next_up_rpt_src_addr = up_rpt_src_addr;
    next_up_rpt_v2       = (up_v2tmr != '0); // RQ18
    for (int g = N_GRP - 1; g >= 0; g--) begin
      if (pend[g]) pick = {1'b1, GW'(g)};
    end
    // emit lowest owed record; a left group reports include-empty
    if (pick[GW]) begin
      next_up_rpt_valid    = 1'b1; // RQ5 RQ4
      next_up_rpt_group    = grp_addr[pick[GW-1:0]];
      next_up_rpt_excl     = db_ex[pick[GW-1:0]];
      next_up_rpt_src_mask = db_src[pick[GW-1:0]];
      for (int s = 0; s < N_SRC; s++) next_up_rpt_src_addr[s*32 +: 32] = src_addr[pick[GW-1:0]][s];
      next_pend[pick[GW-1:0]] = 1'b0;
    end
    // change or upstream query sets pending; set wins over the clear
    for (int g = 0; g < N_GRP; g++) begin
      if (mrg_act[g] != db_act[g] || mrg_ex[g] != db_ex[g] || mrg_src[g] != db_src[g]) begin
        next_pend[g] = 1'b1; // RQ20 RQ5
      end
      if (igmp_valid && en && igmp_if == IFW'(N_CFI) && db_act[g] &&
          (igmp_kind == IMPF_MSG_QUERY_V3 || igmp_kind == IMPF_MSG_QUERY_V2)) begin
        next_pend[g] = 1'b1; // RQ5
      end
    end
  end

  // interface tables: aging on tick, then the arriving message
  always_comb begin
    logic [GW:0]      hit, free;
    logic [GW-1:0]    g;
    logic [N_SRC-1:0] sm, used_s, sfree;
    int               i, sx;
    logic             s_ok;
    hit    = '0;
    free   = '0;
    g      = '0;
    sm     = '0;
    used_s = '0;
    sfree  = '0;
    i      = 0;
    s_ok   = 1'b0;
    sx     = 0;
    next_act = act;  next_excl = excl;  next_v2 = v2;  next_gtmr = gtmr;
    next_v2tmr = v2tmr;  next_lst = lst;  next_stmr = stmr;
    next_grp_addr = grp_addr;  next_src_addr = src_addr;  next_drops = drops;
    // aging, one second per tick
    if (tick) begin
      for (int c = 0; c < N_CFI; c++) begin
        for (int k = 0; k < N_GRP; k++) begin
          if (gtmr[c][k] != '0) next_gtmr[c][k] = gtmr[c][k] - 1'b1;
          if (v2tmr[c][k] != '0) next_v2tmr[c][k] = v2tmr[c][k] - 1'b1;
          else next_v2[c][k] = 1'b0; // RQ17
          for (int s = 0; s < N_SRC; s++) begin
            if (stmr[c][k][s] != '0) next_stmr[c][k][s] = stmr[c][k][s] - 1'b1;
          end
          // exclude record whose group timer ran out falls back to include
          if (act[c][k] && excl[c][k] && next_gtmr[c][k] == '0) next_excl[c][k] = 1'b0;
          if (act[c][k] && !next_excl[c][k]) begin
            for (int s = 0; s < N_SRC; s++) begin
              if (next_stmr[c][k][s] == '0) next_lst[c][k][s] = 1'b0;
            end
            if (next_lst[c][k] == '0) next_act[c][k] = 1'b0; // RQ7
          end
        end
      end
    end
    // message from a customer interface: router role there only
    if (igmp_valid && en && igmp_if < IFW'(N_CFI)) begin // RQ6 RQ1 RQ2
      i = int'(igmp_if);
      for (int k = N_GRP - 1; k >= 0; k--) begin
        if (!grp_used[k]) free = {1'b1, GW'(k)};
      end
      hit = find_grp(igmp_group);
      // other queriers are ignored, whatever their address
      if (igmp_kind != IMPF_MSG_QUERY_V3 && igmp_kind != IMPF_MSG_QUERY_V2) begin // RQ3
        if (hit[GW]) g = hit[GW-1:0];
        else g = free[GW-1:0];
        if (igmp_kind == IMPF_MSG_REPORT12 || igmp_kind == IMPF_MSG_ALLOW || igmp_kind == IMPF_MSG_EXCLUDE) begin
          if (!hit[GW] && !free[GW]) next_drops = (drops == 8'hFF) ? drops : drops + 8'h01;
          else if (!hit[GW]) next_grp_addr[g] = igmp_group;
        end
        // source slot: match first, else one no interface lists
        sm = src_hits(g, igmp_src);
        for (int c = 0; c < N_CFI; c++) used_s = used_s | lst[c][g];
        sm = sm & used_s;
        sfree = ~used_s;
        for (int s = N_SRC - 1; s >= 0; s--) begin
          if (sfree[s]) sx = s;
        end
        for (int s = N_SRC - 1; s >= 0; s--) begin
          if (sm[s]) sx = s;
        end
        s_ok = igmp_has_src && ((sm != '0) || (sfree != '0));
        if (hit[GW] || free[GW]) begin
          case (igmp_kind)
            IMPF_MSG_REPORT12: begin
              // older report: convert to exclude-nothing, only this group goes v2
              next_act[i][g]   = 1'b1; // RQ9
              next_excl[i][g]  = 1'b1;
              next_lst[i][g]   = '0;
              next_gtmr[i][g]  = GMI_SECS;
              next_v2[i][g]    = 1'b1; // RQ17
              next_v2tmr[i][g] = GMI_SECS;
            end
            IMPF_MSG_LEAVE_V2: begin
              if (hit[GW] && act[i][g] && v2[i][g] && gtmr[i][g] > LMQT_SECS) next_gtmr[i][g] = LMQT_SECS;
            end
            IMPF_MSG_ALLOW: begin
              if (!act[i][g]) next_excl[i][g] = 1'b0;
              if (s_ok) begin
                next_act[i][g]          = 1'b1; // RQ7
                next_lst[i][g][sx]      = 1'b1;
                next_stmr[i][g][sx]     = GMI_SECS;
                next_src_addr[g][sx]    = igmp_src;
              end else if (!igmp_has_src) begin
                next_act[i][g] = act[i][g];
              end else begin
                next_drops = (drops == 8'hFF) ? drops : drops + 8'h01;
              end
            end
            IMPF_MSG_EXCLUDE: begin
              // leaving include drops the old list; v2 mode ignores source lists
              if (!act[i][g] || !excl[i][g]) next_lst[i][g] = '0;
              next_act[i][g]  = 1'b1;
              next_excl[i][g] = 1'b1;
              next_gtmr[i][g] = GMI_SECS;
              if (s_ok && !v2[i][g]) begin // RQ17
                next_lst[i][g][sx]   = 1'b1;
                next_stmr[i][g][sx]  = '0;
                next_src_addr[g][sx] = igmp_src;
              end
            end
            IMPF_MSG_BLOCK: begin
              // shorten a running source; ignored in v2 compatibility
              if (hit[GW] && !v2[i][g] && sm != '0 && stmr[i][g][sx] > LMQT_SECS) next_stmr[i][g][sx] = LMQT_SECS;
            end
            default: next_drops = drops;
          endcase
        end
      end
    end
  end

  // per-packet replication decision
  always_comb begin
    logic [GW:0]      fh;
    logic [N_SRC-1:0] sm;
    logic             from_cfi;
    fh = find_grp(pkt_group);
    sm = src_hits(fh[GW-1:0], pkt_src);
    from_cfi = (pkt_if < IFW'(N_CFI));
    next_fwd_valid = pkt_valid;
    next_fwd_mask  = '0;
    // igmp never leaves the interface it came on
    if (pkt_valid && en && !pkt_is_igmp) begin // RQ14
      for (int j = 0; j < N_CFI; j++) begin
        if (pkt_if != IFW'(j)) begin // RQ13
          if (from_cfi && pkt_group[31:16] == LOCAL_SCOPE_PFX) begin
            next_fwd_mask[j] = 1'b1; // RQ15
          end else if (fh[GW] && act[j][fh[GW-1:0]]) begin
            if (excl[j][fh[GW-1:0]]) begin
              next_fwd_mask[j] = ((sm & lst[j][fh[GW-1:0]] & ~running(fh[GW-1:0], j)) == '0); // RQ19 RQ12
            end else begin
              next_fwd_mask[j] = ((sm & lst[j][fh[GW-1:0]] & running(fh[GW-1:0], j)) != '0); // RQ19 RQ12
            end
          end
        end
      end
      next_fwd_mask[N_CFI] = from_cfi && pkt_group[31:24] != ADMIN_SCOPE_PFX; // RQ16 RQ13
    end
  end

  // tick divider, querier, upstream version, register port
  always_comb begin
    next_tcnt       = tick ? '0 : tcnt + 1'b1;
    next_qcnt       = qcnt;
    next_query_mask = '0;
    next_up_v2tmr   = up_v2tmr;
    next_en         = en;
    next_qint       = qint;
    next_reg_rdata  = '0;
    // always querier on every customer interface, no election
    if (tick && en) begin
      if (qcnt == 8'h00) begin
        next_query_mask = '1; // RQ3
        next_qcnt       = (qint == 8'h00) ? 8'h00 : qint - 8'h01;
      end else begin
        next_qcnt = qcnt - 8'h01;
      end
    end
    if (tick && up_v2tmr != '0) next_up_v2tmr = up_v2tmr - 1'b1;
    // an upstream v2 query makes the member side answer in v2 for a while
    if (igmp_valid && en && igmp_if == IFW'(N_CFI) && igmp_kind == IMPF_MSG_QUERY_V2) begin
      next_up_v2tmr = GMI_SECS; // RQ18
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: next_en   = reg_wdata[CTRL_EN_BIT];
        REG_QINT: next_qint = reg_wdata[7:0];
        default:  next_en   = en;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   next_reg_rdata[CTRL_EN_BIT] = en;
        REG_QINT:   next_reg_rdata[7:0] = qint;
        REG_STATUS: begin
          next_reg_rdata[STAT_UPV2_BIT] = (up_v2tmr != '0);
          next_reg_rdata[STAT_DROP_LSB +: 8] = drops;
          next_reg_rdata[STAT_NGRP_LSB +: 8] = 8'($countones(db_act));
        end
        default:    next_reg_rdata = '0;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act <= '{default: 1'b0};  excl <= '{default: 1'b0};  v2 <= '{default: 1'b0};
      gtmr <= '{default: '0};  v2tmr <= '{default: '0};  lst <= '{default: '0};
      stmr <= '{default: '0};  grp_addr <= '{default: '0};  src_addr <= '{default: '0};
      db_src <= '{default: '0};
      drops <= 8'h00;  db_act <= '0;  db_ex <= '0;  pend <= '0;
      tcnt <= '0;  qcnt <= 8'h00;  qint <= QINT_RST;  en <= CTRL_EN_RST;  up_v2tmr <= '0;
      reg_rdata <= '0;  fwd_valid <= 1'b0;  fwd_mask <= '0;  query_mask <= '0;
      up_rpt_valid <= 1'b0;  up_rpt_group <= '0;  up_rpt_excl <= 1'b0;  up_rpt_v2 <= 1'b0;
      up_rpt_src_mask <= '0;  up_rpt_src_addr <= '0;
    end else begin
      act <= next_act;  excl <= next_excl;  v2 <= next_v2;
      gtmr <= next_gtmr;  v2tmr <= next_v2tmr;  lst <= next_lst;
      stmr <= next_stmr;  grp_addr <= next_grp_addr;  src_addr <= next_src_addr;
      db_src <= mrg_src;
      drops <= next_drops;  db_act <= next_db_act;  db_ex <= next_db_ex;  pend <= next_pend;
      tcnt <= next_tcnt;  qcnt <= next_qcnt;  qint <= next_qint;  en <= next_en;  up_v2tmr <= next_up_v2tmr;
      reg_rdata <= next_reg_rdata;  fwd_valid <= next_fwd_valid;  fwd_mask <= next_fwd_mask;
      query_mask <= next_query_mask;
      up_rpt_valid <= next_up_rpt_valid;  up_rpt_group <= next_up_rpt_group;  up_rpt_excl <= next_up_rpt_excl;
      up_rpt_v2 <= next_up_rpt_v2;  up_rpt_src_mask <= next_up_rpt_src_mask;  up_rpt_src_addr <= next_up_rpt_src_addr;
    end
  end
endmodule // impf_proxy_forwarder

/* testbench/impf_sva.sv */
// Purpose: port checker of the multicast proxy forwarder
// Assumes: bound inside the design, one clock domain
// Notes: the enable bit is shadowed from register writes
`timescale 1ns/100ps
module impf_sva
  import impf_pkg::*;
#(
  parameter int N_CFI = 2,
  parameter int IFW   = 2
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic [1:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  input wire logic             pkt_valid,
  input wire logic [IFW-1:0]   pkt_if,
  input wire logic [31:0]      pkt_group,
  input wire logic             pkt_is_igmp,
  input wire logic             fwd_valid,
  input wire logic [N_CFI:0]   fwd_mask,
  input wire logic [N_CFI-1:0] query_mask,
  input wire logic             up_rpt_valid
);
  logic en;     // shadow enable, a write lands one edge later
  logic fwd_ok; // packet that may be forwarded at all
  // shadow enable, the upstream and local scope checks skip disabled spans
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) en <= CTRL_EN_RST;
    else if (reg_wr && reg_addr == REG_CTRL) en <= reg_wdata[CTRL_EN_BIT];
  end
  assign fwd_ok = pkt_valid && en && !pkt_is_igmp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_fwd_lat; fwd_valid == $past(pkt_valid); endproperty
  property p_idle; !fwd_valid |-> fwd_mask == '0; endproperty
  property p_no_back; pkt_valid |=> !fwd_mask[$past(pkt_if)]; endproperty
  property p_igmp; pkt_valid && pkt_is_igmp |=> fwd_mask == '0; endproperty
  property p_up; fwd_ok && pkt_if < N_CFI |=> fwd_mask[N_CFI] == ($past(pkt_group[31:24]) != ADMIN_SCOPE_PFX);
  endproperty
  property p_local; fwd_ok && pkt_if < N_CFI && pkt_group[31:16] == LOCAL_SCOPE_PFX
    |=> (fwd_mask[N_CFI-1:0] | (N_CFI'(1) << $past(pkt_if))) == {N_CFI{1'b1}}; endproperty
  property p_query; query_mask != '0 |-> query_mask == '1 ##1 query_mask == '0; endproperty
  property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_fwd_lat: assert property (p_fwd_lat) else $error("forward answer not one cycle after packet");
  a_idle: assert property (p_idle) else $error("mask set without forward answer");
  a_no_back: assert property (p_no_back) else $error("packet sent back to ingress");
  a_igmp: assert property (p_igmp) else $error("igmp packet relayed");
  a_up: assert property (p_up) else $error("wrong upstream bit");
  a_local: assert property (p_local) else $error("local scope not flooded");
  a_query: assert property (p_query) else $error("query pulse not all interfaces");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  c_local: cover property (fwd_ok && pkt_group[31:16] == LOCAL_SCOPE_PFX);
  c_query: cover property (query_mask != '0);
  c_rpt: cover property (up_rpt_valid);
endmodule // impf_sva
bind impf_proxy_forwarder impf_sva #(.N_CFI(N_CFI), .IFW(IFW)) sva_u (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pkt_valid(pkt_valid), .pkt_if(pkt_if), .pkt_group(pkt_group), .pkt_is_igmp(pkt_is_igmp),
  .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .query_mask(query_mask), .up_rpt_valid(up_rpt_valid));

/* testbench/impf_partner.sv */
// Purpose: cpe hosts and upstream router issuing parsed igmp messages
// Assumes: one message per call, taken at the following edge
// Notes: released group and source go inverted so stale values never look valid
`timescale 1ns/100ps
module impf_partner
  import impf_pkg::*;
#(
  parameter int IFW = 2
) (
  input  wire logic      clk,
  output logic           igmp_valid   = 1'b0,
  output logic [IFW-1:0] igmp_if      = '0,
  output impf_msg_type   igmp_kind    = IMPF_MSG_QUERY_V3,
  output logic [31:0]    igmp_group   = '0,
  output logic [31:0]    igmp_src     = '0,
  output logic           igmp_has_src = 1'b0
);
  // one message, fields held until the taking edge
  task send(input logic [IFW-1:0] i, input impf_msg_type k, input logic [31:0] g, input logic [31:0] s,
            input logic h);
    @(posedge clk);
    igmp_valid   <= 1'b1;
    igmp_if      <= i;
    igmp_kind    <= k;
    igmp_group   <= g;
    igmp_src     <= s;
    igmp_has_src <= h;
    @(posedge clk);
    igmp_valid   <= 1'b0;
    igmp_group   <= ~g;
    igmp_src     <= ~s;
  endtask
endmodule // impf_partner

/* testbench/tb_impf_proxy_forwarder.sv */
// Purpose: self-checking bench of the multicast proxy forwarder
// Assumes: shortened tick so query timing runs quickly
// Notes: two customer interfaces, three joins
`timescale 1ns/100ps
module tb_impf_proxy_forwarder
  import impf_pkg::*; ;
  logic         clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pkt_valid = 1'b0, pkt_is_igmp = 1'b0;
  logic [1:0]   reg_addr = '0, pkt_if = '0, igmp_if, query_mask, up_rpt_src_mask;
  logic [31:0]  reg_wdata = '0, pkt_group = '0, pkt_src = '0, reg_rdata, igmp_group, igmp_src, up_rpt_group;
  logic [2:0]   fwd_mask;
  logic         igmp_valid, igmp_has_src, fwd_valid, up_rpt_valid, up_rpt_excl, up_rpt_v2;
  impf_msg_type igmp_kind;
  int           num_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  impf_proxy_forwarder #(.TICK_CYC(20)) dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .igmp_valid(igmp_valid),
    .igmp_if(igmp_if), .igmp_kind(igmp_kind), .igmp_group(igmp_group), .igmp_src(igmp_src),
    .igmp_has_src(igmp_has_src), .pkt_valid(pkt_valid), .pkt_if(pkt_if), .pkt_group(pkt_group),
    .pkt_src(pkt_src), .pkt_is_igmp(pkt_is_igmp), .fwd_valid(fwd_valid), .fwd_mask(fwd_mask),
    .query_mask(query_mask), .up_rpt_valid(up_rpt_valid), .up_rpt_group(up_rpt_group), .up_rpt_excl(up_rpt_excl),
    .up_rpt_v2(up_rpt_v2), .up_rpt_src_mask(up_rpt_src_mask), .up_rpt_src_addr());
  impf_partner p_u (.clk(clk), .igmp_valid(igmp_valid), .igmp_if(igmp_if), .igmp_kind(igmp_kind),
    .igmp_group(igmp_group), .igmp_src(igmp_src), .igmp_has_src(igmp_has_src));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task close_out;
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [1:0] a, input logic [31:0] e);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task pk(input logic [1:0] i, input logic [31:0] g, input logic [31:0] s, input logic ig, input logic [2:0] e);
    @(posedge clk);
    {pkt_valid, pkt_if, pkt_group, pkt_src, pkt_is_igmp} <= {1'b1, i, g, s, ig};
    @(posedge clk);
    pkt_valid <= 1'b0;
    #1 chk({31'h0, fwd_valid}, 32'h1);
    chk({29'h0, fwd_mask}, {29'h0, e});
  endtask
  // bounded wait for one upstream record
  task rpt(input logic [31:0] g, input logic x);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 20 && !seen; n++) begin
      @(posedge clk);
      #1 seen = (up_rpt_valid === 1'b1);
    end
    chk({31'h0, seen}, 32'h1);
    chk(up_rpt_group, g);
    chk({31'h0, up_rpt_excl}, {31'h0, x});
    chk({30'h0, up_rpt_src_mask}, 32'h0);
    chk({31'h0, up_rpt_v2}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_QINT, {24'h0, QINT_RST});
    rd(REG_CTRL, 32'h1);
    rd(2'h3, 32'h0);
    rd(REG_STATUS, 32'h0);
    wr(REG_QINT, 32'h5);
    rd(REG_QINT, 32'h5);
    p_u.send(2'd0, IMPF_MSG_REPORT12, 32'hE0006401, 32'h0, 1'b0);
    rpt(32'hE0006401, 1'b1);
    p_u.send(2'd0, IMPF_MSG_EXCLUDE, 32'hE0806401, 32'h0, 1'b0);
    rpt(32'hE0806401, 1'b1);
    p_u.send(2'd1, IMPF_MSG_EXCLUDE, 32'hE0806401, 32'hC6C8C8C8, 1'b1);
    repeat (10) @(posedge clk);
    pk(2'd2, 32'hE000C802, 32'hC6646464, 1'b0, 3'b000);
    pk(2'd2, 32'hE0006401, 32'hC6646464, 1'b0, 3'b001);
    pk(2'd2, 32'hE0806401, 32'hC6646464, 1'b0, 3'b011);
    pk(2'd2, 32'hE0806401, 32'hC6C8C8C8, 1'b0, 3'b001);
    pk(2'd0, 32'hE0006401, 32'hC6646464, 1'b0, 3'b100);
    pk(2'd1, 32'hEFFF0101, 32'hC0A80002, 1'b0, 3'b001);
    pk(2'd0, 32'hEF010101, 32'hC0A80002, 1'b0, 3'b000);
    pk(2'd0, 32'hE0006401, 32'hC0A80002, 1'b1, 3'b000);
    rd(REG_STATUS, 32'h00020000);
    p_u.send(2'd2, IMPF_MSG_QUERY_V3, 32'h0, 32'h0, 1'b0);
    rpt(32'hE0006401, 1'b1);
    for (int n = 0; n < 400 && query_mask !== 2'b11; n++) begin
      @(posedge clk);
      #1;
    end
    chk({30'h0, query_mask}, 32'h3);
    wr(REG_CTRL, 32'h0);
    pk(2'd2, 32'hE0006401, 32'hC6646464, 1'b0, 3'b000);
    wr(REG_CTRL, 32'h1);
    close_out;
  end
  // watchdog, far past the run length
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule // tb_impf_proxy_forwarder
